// [cpwm_pkg.sv]
// Package for the capture/PWM output time base: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz system clock.
package cpwm_pkg;
  localparam int          AXI_AW           = 4;
  localparam logic [3:0]  OFS_PERIOD_LIMIT = 4'h0;
  localparam logic [3:0]  OFS_DUTY_HIGH    = 4'h4;
  localparam logic [3:0]  OFS_CONTROL      = 4'h8;
  localparam logic [3:0]  OFS_STATUS       = 4'hc;
  localparam int          CTL_DLOW_LSB     = 4;
  localparam int          CTL_PRE_LSB      = 0;
  localparam int          CTL_EN_BIT       = 2;
  localparam logic [7:0]  RST_PERIOD_LIMIT = 8'hff;
  localparam logic [7:0]  RST_DUTY_HIGH    = 8'h00;
  localparam logic [5:0]  RST_CONTROL      = 6'h00;
  localparam logic [1:0]  PRE_DIV1         = 2'h0;
  localparam logic [1:0]  PRE_DIV4         = 2'h1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam int          OSC_PER_INSTR    = 4;
  localparam logic [31:0] BLOCK_ID         = 32'h0000_5a01; // Arbitrary value
endpackage : cpwm_pkg

// [cpwm_timebase.sv]
// Prescaled 10-bit PWM time base: oscillator phase, prescaler and period timer.
// Assumes the enable and prescale selection come from the register block on the same clock.
`timescale 1ns/10ps
module cpwm_timebase
  import cpwm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [1:0] prescale,
  input  wire logic [7:0] period_limit,
  output logic      [9:0] time_base,
  output logic            rollover,
  output logic            tick
);
  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] pre;
    logic [7:0] timer;
  } cpwm_tb_t;
  cpwm_tb_t s_r, s_nxt;
  logic inc;
  logic [1:0] low2;

  always_comb begin
    s_nxt = s_r;
    inc   = 1'b0;
    low2  = 2'b00;
    if (!run) begin
      s_nxt = '0;
    end else begin
      s_nxt.phase = s_r.phase + 2'd1;
      if (s_r.phase == 2'd3) begin
        // Prescaler advances once per instruction cycle
        case (prescale)
          PRE_DIV1: begin
            inc = 1'b1;
            s_nxt.pre = 4'h0;
          end
          PRE_DIV4: begin
            inc = (s_r.pre[1:0] == 2'd3);
            s_nxt.pre = {2'b00, s_r.pre[1:0] + 2'd1};
          end
          default: begin
            inc = (s_r.pre == 4'hf);
            s_nxt.pre = s_r.pre + 4'h1;
          end
        endcase
      end
      if (inc) begin
        // Clear after match on next increment
        s_nxt.timer = (s_r.timer == period_limit) ? 8'h00 : s_r.timer + 8'h01;
      end
    end
    // Two low bits of the next state: oscillator phase at 1:1, prescaler bits otherwise
    case (prescale)
      PRE_DIV1: low2 = s_nxt.phase;
      PRE_DIV4: low2 = s_nxt.pre[1:0];
      default:  low2 = s_nxt.pre[3:2];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r       <= '0;
      time_base <= 10'h000;
      rollover  <= 1'b0;
      tick      <= 1'b0;
    end else begin
      s_r       <= s_nxt;
      time_base <= {s_nxt.timer, low2};
      rollover  <= inc && (s_r.timer == period_limit);
      tick      <= inc;
    end
  end
endmodule : cpwm_timebase

// [cpwm_top.sv]
// Single-output PWM with 8-bit period timer, 10-bit time base and double-buffered duty.
// Assumes an AXI4-Lite master on aclk; pwm_out goes straight to a pin.
//
// Contract
// - Period equals (period_limit+1) times 4 oscillator periods times prescale.
// - Timer clears on the increment after it equals period_limit.
// - Output goes high at period start unless duty is zero.
// - At rollover pending duty high byte and low bits load active duty.
// - No postscaler affects the PWM period.
// - Duty is 10 bits: write-high byte over two control low bits.
// - Duty writes take effect only after the current period ends.
// - Active duty high byte is read-only while PWM runs.
// - High time equals duty times oscillator period times prescale.
// - Active duty plus hidden 2-bit latch double-buffer the duty; here the latch reads back in status bits 1:0.
// - Time base is timer over phase bits or prescaler bits.
// - Output falls when time base equals active 10-bit duty.
// - Pulse width above period leaves output unchanged.
// - Prescale factors are exactly 1, 4 and 16.
// - Full 10-bit resolution is reached when period_limit is 255.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module cpwm_top
  import cpwm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pwm_out
);
  import cpwm_pkg::*;

  typedef struct packed {
    logic        aw_full;
    logic [3:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  period_limit;
    logic [7:0]  duty_write_high;
    logic [7:0]  duty_active_high;
    logic [1:0]  duty_latch;
    logic [5:0]  control;
    logic        pwm;
    logic        started;
  } cpwm_state_t;

  cpwm_state_t s_r, s_nxt;
  logic [9:0]  time_base;
  logic        rollover;
  logic        tick;
  logic        run;
  logic [9:0]  next_duty;
  logic        wr_go;

  function automatic logic [31:0] cpwm_read(input logic [3:0] a, input cpwm_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == OFS_PERIOD_LIMIT) begin
      d = {24'h0, s.period_limit};
    end else if (a == OFS_DUTY_HIGH) begin
      d = {16'h0, s.duty_active_high, s.duty_write_high};
    end else if (a == OFS_CONTROL) begin
      d = {26'h0, s.control};
    end else if (a == OFS_STATUS) begin
      d = {22'h0, s.pwm, s.started, 6'h0, s.duty_latch};
    end
    return d;
  endfunction : cpwm_read

  function automatic logic cpwm_mapped(input logic [3:0] a);
    return (a[1:0] == 2'b00);
  endfunction : cpwm_mapped

  assign run = s_r.control[CTL_EN_BIT];

  cpwm_timebase u_tb (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .run          (run),
    .prescale     (s_r.control[CTL_PRE_LSB +: 2]),
    .period_limit (s_r.period_limit),
    .time_base    (time_base),
    .rollover     (rollover),
    .tick         (tick)
  );

  always_comb begin
    s_nxt     = s_r;
    wr_go     = s_r.aw_full && s_r.w_full && !s_r.bvalid;
    next_duty = {s_r.duty_write_high, s_r.control[CTL_DLOW_LSB +: 2]};
    if (s_axi_awvalid && !s_r.aw_full) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_full) begin
      s_nxt.w_full = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = cpwm_mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (s_r.w_strb[0]) begin
        if (s_r.aw_addr == OFS_PERIOD_LIMIT) begin
          s_nxt.period_limit = s_r.w_data[7:0];
        end else if (s_r.aw_addr == OFS_DUTY_HIGH) begin
          s_nxt.duty_write_high = s_r.w_data[7:0];
        end else if (s_r.aw_addr == OFS_CONTROL) begin
          s_nxt.control = s_r.w_data[5:0];
          if (s_r.w_data[CTL_PRE_LSB +: 2] == 2'b11) begin
            s_nxt.control[CTL_PRE_LSB +: 2] = 2'b10;
          end
        end
      end
      if (s_r.w_strb[1] && s_r.aw_addr == OFS_DUTY_HIGH && !run) begin
        s_nxt.duty_active_high = s_r.w_data[15:8];
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = cpwm_read(s_axi_araddr, s_r);
      s_nxt.rresp  = cpwm_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // PWM output sequencing
    if (!run) begin
      s_nxt.pwm     = 1'b0;
      s_nxt.started = 1'b0;
    end else if (rollover || !s_r.started) begin
      s_nxt.started          = 1'b1;
      s_nxt.duty_active_high = next_duty[9:2];
      s_nxt.duty_latch       = next_duty[1:0];
      s_nxt.pwm              = (next_duty != 10'h000);
    end else if (time_base == {s_r.duty_active_high, s_r.duty_latch}) begin
      s_nxt.pwm = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r                  <= '0;
      s_r.period_limit     <= RST_PERIOD_LIMIT;
      s_r.duty_write_high  <= RST_DUTY_HIGH;
      s_r.duty_active_high <= RST_DUTY_HIGH;
      s_r.control          <= RST_CONTROL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_full;
  assign s_axi_wready  = !s_r.w_full;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign pwm_out       = s_r.pwm;

  sequence s_wr_ready;
    s_r.aw_full && s_r.w_full && !s_r.bvalid;
  endsequence
  sequence s_rsp_up;
    s_r.bvalid && !s_r.aw_full && !s_r.w_full;
  endsequence

  a_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> !pwm_out) else $error("pwm high while disabled");
  a_zero_duty: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && rollover && next_duty == 10'h000) |=> !pwm_out)
    else $error("zero duty set output");
  a_start_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && s_r.started && rollover && next_duty != 10'h000) |=> pwm_out)
    else $error("period start not high");
  a_duty_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && rollover) |=> {s_r.duty_active_high, s_r.duty_latch} == $past(next_duty))
    else $error("duty not loaded at rollover");
  a_duty_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && s_r.started && !rollover) |=> $stable(s_r.duty_latch))
    else $error("latch changed mid period");
  a_active_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && s_r.started && !rollover) |=> $stable(s_r.duty_active_high))
    else $error("active duty written while running");
  a_match_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && s_r.started && !rollover && time_base == {s_r.duty_active_high, s_r.duty_latch})
    |=> !pwm_out) else $error("no clear on match");
  a_no_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && !rollover && s_r.started && !pwm_out) |=> !pwm_out)
    else $error("output rose mid period");
  a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.bvalid && !s_axi_bready) |=> s_r.bvalid)
    else $error("write response dropped");
  a_roll_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    rollover |-> tick) else $error("rollover without timer step");
  a_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick [*3]) else $error("timer stepped faster than instruction cycle");
  a_base_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && rollover) |-> time_base == 10'h000) else $error("time base not cleared");
  a_base_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && $stable(s_r.control) && s_r.control[CTL_PRE_LSB +: 2] == PRE_DIV1 && !rollover)
    |-> time_base == $past(time_base) + 10'h001) else $error("time base skipped a step");
  a_pre_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.control[CTL_PRE_LSB +: 2] != 2'b11) else $error("illegal prescale stored");
  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_ready |=> s_rsp_up) else $error("write not answered");
  a_rd_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.rvalid && !s_axi_rready) |=> (s_r.rvalid && $stable(s_r.rdata)))
    else $error("read data dropped");
endmodule : cpwm_top

// [test_capture_pwm_output_timebase.sv]
// Self-checking bench for the PWM block: period, pulse width, buffering, read-only duty.
// Assumes an AXI4-Lite slave; bus waits end only at the cycle ceiling, pulse waits also stop after 3000 cycles.
`timescale 1ns/10ps
module test_capture_pwm_output_timebase;
  import cpwm_pkg::*;
  logic aclk = 0, aresetn = 0, pwm_out;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failures = 0, total_checks = 0, cyc = 0, hi, per, t0;
  always #25 aclk = ~aclk;
  cpwm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_out(pwm_out));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] v, logic [3:0] s = 4'h1);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", RESP_OKAY, bresp);
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd
  task automatic cfg(logic [7:0] pl, logic [7:0] dh, logic [1:0] lo, logic [1:0] pre);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_PERIOD_LIMIT, {24'h0, pl});
    wr(OFS_DUTY_HIGH, {24'h0, dh});
    wr(OFS_CONTROL, {26'h0, lo, 2'h1, pre});
  endtask : cfg
  task automatic meas();
    int n;
    n = 0;
    do @(negedge aclk); while (pwm_out !== 1'b0 && n++ < 3000);
    do @(negedge aclk); while (pwm_out !== 1'b1 && n++ < 3000);
    hi = 0;
    do begin hi++; @(negedge aclk); end while (pwm_out === 1'b1 && hi < 3000);
    per = hi;
    do begin per++; @(negedge aclk); end while (pwm_out !== 1'b1 && per < 3000);
  endtask : meas
  task automatic count_high(int len);
    hi = 0;
    repeat (len) begin
      @(negedge aclk);
      if (pwm_out === 1'b1) hi++;
    end
  endtask : count_high
  task automatic t_reset();
    logic [1:0] r;
    chk("pwm_reset", 0, pwm_out);
    rd(OFS_PERIOD_LIMIT, d, r);
    chk("period_limit", RST_PERIOD_LIMIT, d);
    rd(4'h2, d, r);
    chk("unmapped_resp", RESP_SLVERR, r);
  endtask : t_reset
  task automatic t_rates();
    int tb[5][6] = '{'{0, 3, 1, 2, 6, 16}, '{1, 1, 1, 1, 20, 32}, '{2, 0, 0, 3, 48, 64},
                     '{3, 0, 0, 1, 16, 64}, '{0, 255, 0, 1, 1, 1024}};
    foreach (tb[i]) begin
      cfg(tb[i][1], tb[i][2], tb[i][3], tb[i][0]);
      meas();
      chk("high_width", tb[i][4], hi);
      chk("period", tb[i][5], per);
    end
  endtask : t_rates
  task automatic t_edges();
    cfg(8'h03, 8'h00, 2'h0, PRE_DIV1);
    count_high(64);
    chk("zero_duty_high", 0, hi);
    cfg(8'h03, 8'hff, 2'h3, PRE_DIV1);
    repeat (20) @(negedge aclk);
    count_high(64);
    chk("over_duty_high", 64, hi);
  endtask : t_edges
  task automatic t_buffer();
    logic [1:0] r;
    cfg(8'h03, 8'h01, 2'h2, PRE_DIV4);
    meas();
    t0 = cyc;
    wr(OFS_DUTY_HIGH, 32'h0);
    wr(OFS_CONTROL, {26'h0, 2'h2, 2'h1, PRE_DIV4});
    do @(negedge aclk); while (pwm_out === 1'b1 && cyc - t0 < 3000);
    chk("pulse_in_flight", 24, cyc - t0);
    meas();
    chk("pulse_after_update", 8, hi);
    wr(OFS_DUTY_HIGH, 32'h0000_5503, 4'h3);
    rd(OFS_DUTY_HIGH, d, r);
    chk("duty_regs", 32'h0000_0003, d & 32'h0000_ffff);
    wr(OFS_CONTROL, 32'h0);
    repeat (4) @(negedge aclk);
    count_high(64);
    chk("disabled_high", 0, hi);
    rd(OFS_STATUS, d, r);
    chk("status_latch", 32'h0000_0002, d);
    wr(OFS_DUTY_HIGH, 32'h0000_5503, 4'h3);
    rd(OFS_DUTY_HIGH, d, r);
    chk("duty_idle_write", 32'h0000_5503, d);
  endtask : t_buffer
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_rates();
    t_edges();
    t_buffer();
    wrap_up();
  end
endmodule : test_capture_pwm_output_timebase
